/* File: rtl/err_flag_consts.svh */
// Constants for the receiver error and flag output block
`ifndef ERR_FLAG_CONSTS_SVH
`define ERR_FLAG_CONSTS_SVH
`define PERR_CONCEAL_MAX  4'h8
`define PERR_CNT_W        4
`define CS_BITS           8'hC0
`define CS_NONPCM_BIT     1
`define CS_EMPH_BIT       3
`define DTS_CHECK_FRAMES  13'h1000
`define DTS_SYNC_14       28'h1FFFE80
`define IEC_SYNC_PA       16'hF872
`define IEC_SYNC_PB       16'h4E1F
`define MULTI_STATUS_OUT_SEL_EMPH     1'h1
`define ADDR_CTRL         4'h0
`define ADDR_STAT         4'h4
`define CTRL_RST          8'h00
`endif

/* File: rtl/err_flag_pkg.sv */
// Types for the receiver error and flag output block
package err_flag_pkg;
    typedef enum logic [1:0] {
        ST_LOCKED_OK = 2'b00,
        ST_CONCEAL   = 2'b01,
        ST_MUTED     = 2'b10
    } err_state_t;
endpackage

/* File: rtl/spdif_rx_err_out.sv */
// Error concealment, status pins, sync detection and GPIO selector
`timescale 1ns/1ns
`include "err_flag_consts.svh"
// Overview of operation
// - Up to 8 parity-error frames on PCM repeat last good L/R sample
// - Up to 8 parity-error frames on non-PCM pass data unchanged
// - Non-PCM means CS bit 1 high, captured before the error run
// - Lock error or 9+ parity errors mute data and status; fs only on lock
// - Short parity error runs hold each status bit from previous block
// - Lock declared once block, A and B preambles all seen
// - Output restarts at first word clock edge after error flag falls
// - Non-PCM pin follows CS bit 1
// - Non-PCM pin updates at once on error flag, even if high
// - Source select ORs sync detect flags onto non-PCM pin
// - Multi-status pin shows emphasis when that output is selected
// - Emphasis on multi-status pin updates at once on error flag
// - IEC61937 sync flag only raised for non-PCM streams
// - 14-bit sync checked every 4096th frame, held until it fails
// - Interrupt source enabled: active-low irq on either sync detection
// - Sync flags cleared on fs change, lock error or data error
// - Pin mode 1 forms 4-bit 2-to-1 clock/data selector
// - External select only acts in pin mode 1
// - External master clock optionally inverted
// - External data mute; invert and mute need pin mode 1
// - Error flag raised on lock loss or data error, word-clock aligned
module spdif_rx_err_out
    import err_flag_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // Demodulator side (same clock domain)
    input  wire logic        i_frame_stb,
    input  wire logic        i_parity_err,
    input  wire logic [23:0] i_sample_l,
    input  wire logic [23:0] i_sample_r,
    input  wire logic [7:0]  i_cs_byte0,
    input  wire logic        i_block_stb,
    input  wire logic        i_pre_b_seen,
    input  wire logic        i_pre_a_seen,
    input  wire logic        i_pre_bb_seen,
    input  wire logic        i_pll_err,
    input  wire logic        i_fs_changed,
    input  wire logic [3:0]  i_fs_meas,
    // Receiver serial outputs and crystal side
    input  wire logic        i_rx_master_clock,
    input  wire logic        i_rx_bit_clock,
    input  wire logic        i_rx_word_clock,
    input  wire logic        i_rx_data,
    input  wire logic        i_xtal_mclk,
    input  wire logic        i_xtal_bclk,
    input  wire logic        i_xtal_lrclk,
    input  wire logic        i_aux_serial_in,
    input  wire logic [3:0]  i_gpio,
    // Register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // Processed outputs
    output logic      [23:0] o_data_l,
    output logic      [23:0] o_data_r,
    output logic      [7:0]  o_cs_byte0,
    output logic      [3:0]  o_fs_meas,
    output logic             o_data_valid,
    output logic             o_error_flag_out,
    output logic             o_nonpcm,
    output logic             o_multi_status_out,
    output logic             o_irq_n,
    output logic             o_locked,
    // Selector outputs
    output logic             o_mclk,
    output logic             o_bclk,
    output logic             o_lrclk,
    output logic             o_sdata
);

    err_state_t st_q;
    logic [`PERR_CNT_W-1:0] perr_cnt_q;
    logic [23:0] last_l_q, last_r_q;
    logic [7:0]  cs_hold_q;
    logic        nonpcm_cap_q;
    logic [7:0]  ctrl_q;
    logic        iec_flag_q, dts_flag_q;
    logic [12:0] dts_frames_q;
    logic        lock_q;
    logic [1:0]  lr_prev_q;
    logic        lr_edge;
    logic        data_err;
    logic [3:0]  ext_s1_q, ext_s2_q;
    logic [3:0]  rx_s1_q, rx_s2_q;
    logic [3:0]  xt_s1_q, xt_s2_q;

    // Control bits
    wire status_pin_source_select = ctrl_q[0];
    wire multi_out_select         = ctrl_q[1];
    wire nonpcm_irq_source        = ctrl_q[2];
    wire pin_mode_select          = ctrl_q[3];
    wire external_source_select   = ctrl_q[4];
    wire ext_mclk_invert          = ctrl_q[5];
    wire ext_data_mute            = ctrl_q[6];

    function automatic logic sync_hit(input logic [23:0] s);
        sync_hit = (s[23:8] == `IEC_SYNC_PA) || (s[23:8] == `IEC_SYNC_PB);
    endfunction

    // Synchronisers for pin-level clocks and data
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_s1_q <= 4'h0;
            ext_s2_q <= 4'h0;
            rx_s1_q  <= 4'h0;
            rx_s2_q  <= 4'h0;
            xt_s1_q  <= 4'h0;
            xt_s2_q  <= 4'h0;
        end else begin
            ext_s1_q <= i_gpio;
            ext_s2_q <= ext_s1_q;
            rx_s1_q  <= {i_rx_data, i_rx_word_clock, i_rx_bit_clock,
                         i_rx_master_clock};
            rx_s2_q  <= rx_s1_q;
            xt_s1_q  <= {i_aux_serial_in, i_xtal_lrclk, i_xtal_bclk,
                         i_xtal_mclk};
            xt_s2_q  <= xt_s1_q;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lr_prev_q <= 2'h0;
        end else begin
            lr_prev_q <= {lr_prev_q[0], rx_s2_q[2]};
        end
    end
    assign lr_edge  = lr_prev_q[1] ^ lr_prev_q[0];
    assign data_err = (perr_cnt_q > `PERR_CONCEAL_MAX);

    // Lock declared after all three preambles
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_q <= 1'b0;
        end else if (i_pll_err) begin
            lock_q <= 1'b0;
        end else if (i_pre_b_seen && i_pre_a_seen && i_pre_bb_seen) begin
            lock_q <= 1'b1;
        end
    end

    // Consecutive parity error count
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            perr_cnt_q <= '0;
        end else if (i_frame_stb) begin
            if (!i_parity_err) begin
                perr_cnt_q <= '0;
            end else if (!data_err) begin
                perr_cnt_q <= perr_cnt_q + 1'b1;
            end
        end
    end

    // Error flag changes only on word clock edges
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_error_flag_out <= 1'b1;
        end else if (lr_edge) begin
            o_error_flag_out <= !lock_q || data_err;
        end
    end

    // Output state
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_MUTED;
        end else begin
            case (st_q)
                ST_LOCKED_OK: begin
                    if (!lock_q || data_err) begin
                        st_q <= ST_MUTED;
                    end else if (i_frame_stb && i_parity_err) begin
                        st_q <= ST_CONCEAL;
                    end
                end
                ST_CONCEAL: begin
                    if (!lock_q || data_err) begin
                        st_q <= ST_MUTED;
                    end else if (i_frame_stb && !i_parity_err) begin
                        st_q <= ST_LOCKED_OK;
                    end
                end
                ST_MUTED: begin
                    if (!o_error_flag_out && lr_edge) begin
                        st_q <= ST_LOCKED_OK;
                    end
                end
                default: st_q <= ST_MUTED;
            endcase
        end
    end

    // Non-PCM class captured while clean
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nonpcm_cap_q <= 1'b0;
        end else if (i_block_stb && !i_parity_err && perr_cnt_q == '0) begin
            nonpcm_cap_q <= i_cs_byte0[`CS_NONPCM_BIT];
        end
    end

    // Sample data with concealment
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data_l     <= 24'h0;
            o_data_r     <= 24'h0;
            last_l_q     <= 24'h0;
            last_r_q     <= 24'h0;
            o_data_valid <= 1'b0;
        end else if (st_q == ST_MUTED || !lock_q || data_err) begin
            o_data_l     <= 24'h0;
            o_data_r     <= 24'h0;
            o_data_valid <= 1'b0;
        end else if (i_frame_stb) begin
            o_data_valid <= 1'b1;
            if (!i_parity_err) begin
                o_data_l <= i_sample_l;
                o_data_r <= i_sample_r;
                last_l_q <= i_sample_l;
                last_r_q <= i_sample_r;
            end else if (nonpcm_cap_q) begin
                o_data_l <= i_sample_l;
                o_data_r <= i_sample_r;
            end else begin
                o_data_l <= last_l_q;
                o_data_r <= last_r_q;
            end
        end
    end

    // Channel status and fs output
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_hold_q  <= 8'h0;
            o_cs_byte0 <= 8'h0;
        end else if (!lock_q || data_err) begin
            o_cs_byte0 <= 8'h0;
        end else if (i_block_stb) begin
            if (perr_cnt_q == '0 && !i_parity_err) begin
                cs_hold_q  <= i_cs_byte0;
                o_cs_byte0 <= i_cs_byte0;
            end else begin
                o_cs_byte0 <= cs_hold_q;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fs_meas <= 4'h0;
        end else begin
            o_fs_meas <= i_pll_err ? 4'h0 : i_fs_meas;
        end
    end

    // IEC61937 sync detection
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            iec_flag_q <= 1'b0;
        end else if (i_fs_changed || !lock_q || data_err
                     || !nonpcm_cap_q) begin
            iec_flag_q <= 1'b0;
        end else if (i_frame_stb && !i_parity_err && sync_hit(i_sample_l)) begin
            iec_flag_q <= 1'b1;
        end
    end

    // 14-bit packed sync checked every 4096th frame
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dts_frames_q <= 13'h0;
            dts_flag_q   <= 1'b0;
        end else if (i_fs_changed || !lock_q || data_err) begin
            dts_frames_q <= 13'h0;
            dts_flag_q   <= 1'b0;
        end else if (i_frame_stb) begin
            if (dts_frames_q == `DTS_CHECK_FRAMES - 13'h1) begin
                dts_frames_q <= 13'h0;
                dts_flag_q   <= ({i_sample_l, i_sample_r[23:20]}
                                 == `DTS_SYNC_14);
            end else begin
                dts_frames_q <= dts_frames_q + 13'h1;
            end
        end
    end

    // Status pins update immediately, whatever the error flag
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_nonpcm           <= 1'b0;
            o_multi_status_out <= 1'b0;
            o_irq_n            <= 1'b1;
            o_locked           <= 1'b0;
        end else begin
            o_nonpcm <= i_cs_byte0[`CS_NONPCM_BIT]
                        | (status_pin_source_select
                           & (iec_flag_q | dts_flag_q));
            o_multi_status_out <= (multi_out_select == `MULTI_STATUS_OUT_SEL_EMPH)
                                  ? i_cs_byte0[`CS_EMPH_BIT]
                                  : (i_fs_meas != 4'h0);
            o_irq_n  <= !(nonpcm_irq_source
                          & (iec_flag_q | dts_flag_q));
            o_locked <= lock_q;
        end
    end

    // Register port
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= `CTRL_RST;
        end else if (i_wr && i_addr == `ADDR_CTRL) begin
            ctrl_q <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h0;
        end else if (i_rd) begin
            case (i_addr)
                `ADDR_CTRL: o_rdata <= ctrl_q;
                `ADDR_STAT: o_rdata <= {4'h0, o_error_flag_out, lock_q,
                                        dts_flag_q, iec_flag_q};
                default:    o_rdata <= 8'h0;
            endcase
        end else begin
            o_rdata <= 8'h0;
        end
    end

    // 2-to-1 selector for clocks and data
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mclk  <= 1'b0;
            o_bclk  <= 1'b0;
            o_lrclk <= 1'b0;
            o_sdata <= 1'b0;
        end else if (pin_mode_select && external_source_select) begin
            o_mclk  <= ext_s2_q[0] ^ ext_mclk_invert;
            o_bclk  <= ext_s2_q[1];
            o_lrclk <= ext_s2_q[2];
            o_sdata <= ext_s2_q[3] & !ext_data_mute;
        end else if (lock_q) begin
            o_mclk  <= rx_s2_q[0];
            o_bclk  <= rx_s2_q[1];
            o_lrclk <= rx_s2_q[2];
            o_sdata <= rx_s2_q[3];
        end else begin
            o_mclk  <= xt_s2_q[0];
            o_bclk  <= xt_s2_q[1];
            o_lrclk <= xt_s2_q[2];
            o_sdata <= xt_s2_q[3];
        end
    end

    // Data and status muted the cycle after lock is lost
    mute_on_err_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (!lock_q) |=> (o_data_l == 24'h0 && o_cs_byte0 == 8'h0))
        else $error("data not muted on lock error");
    conceal_pcm_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_q != ST_MUTED && lock_q && !data_err && i_frame_stb
         && i_parity_err && !nonpcm_cap_q)
        |=> (o_data_l == $past(last_l_q)))
        else $error("pcm sample not concealed");
    pass_nonpcm_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_q != ST_MUTED && lock_q && !data_err && i_frame_stb
         && i_parity_err && nonpcm_cap_q)
        |=> (o_data_r == $past(i_sample_r)))
        else $error("non-pcm data not passed");
    perr_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_frame_stb && !i_parity_err) |=> (perr_cnt_q == '0))
        else $error("parity count not cleared");
    flag_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_fs_changed) |=> (!iec_flag_q && !dts_flag_q))
        else $error("sync flags not cleared");
    irq_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (nonpcm_irq_source && iec_flag_q) |=> !o_irq_n)
        else $error("irq not asserted");
    ext_mute_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (pin_mode_select && external_source_select && ext_data_mute)
        |=> !o_sdata)
        else $error("external data not muted");
    errflag_lr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $changed(o_error_flag_out) |-> $past(lr_edge))
        else $error("error flag changed off word clock edge");

endmodule

/* File: tb/spdif_src_model.sv */
// Bi-phase source model: free-running word clock and demodulated frames
`timescale 1ns/1ns
module spdif_src_model (
    // Clock
    input  wire logic        i_mclk,
    // Frame side
    output logic             o_frame_stb,
    output logic             o_parity_err,
    output logic      [23:0] o_sample_l,
    output logic      [23:0] o_sample_r,
    output logic             o_word_clock,
    output logic             o_block_stb
);
    initial begin
        o_frame_stb  = 1'h0;
        o_parity_err = 1'h0;
        o_sample_l   = 24'h0;
        o_sample_r   = 24'h0;
        o_word_clock = 1'h0;
        o_block_stb  = 1'h0;
        #37;
        forever #80 o_word_clock = ~o_word_clock;
    end

    // One frame: strobe for one cycle, L and R travel together
    task automatic send(input logic [23:0] l, input logic [23:0] r,
                        input logic perr, input logic blk);
        @(posedge i_mclk);
        o_frame_stb  <= 1'h1;
        o_block_stb  <= blk;
        o_parity_err <= perr;
        o_sample_l   <= l;
        o_sample_r   <= r;
        @(posedge i_mclk);
        o_frame_stb  <= 1'h0;
        o_block_stb  <= 1'h0;
        // Released lines show the inverse, not the old value
        o_parity_err <= ~perr;
        o_sample_l   <= ~l;
        o_sample_r   <= ~r;
    endtask
endmodule

/* File: tb/spdif_rx_err_out_tb.sv */
// Self-checking bench for the error and flag output block
`timescale 1ns/1ns
`include "err_flag_consts.svh"
module spdif_rx_err_out_tb;
    logic        i_mclk, i_rst_n, i_frame_stb, i_parity_err, i_block_stb;
    logic [23:0] i_sample_l, i_sample_r, o_data_l, o_data_r;
    logic [7:0]  i_cs_byte0, i_wdata, o_rdata, o_cs_byte0;
    logic        i_pre, i_pll_err, i_fs_changed, i_rx_word_clock;
    logic [3:0]  i_fs_meas, i_gpio, i_addr, o_fs_meas;
    logic        i_rx_master_clock, i_rx_bit_clock, i_rx_data, i_wr, i_rd;
    logic        i_xtal_mclk, i_xtal_bclk, i_xtal_lrclk, i_aux_serial_in;
    logic        o_data_valid, o_error_flag_out, o_nonpcm, o_irq_n;
    logic        o_multi_status_out, o_locked, o_mclk, o_bclk, o_lrclk;
    logic        o_sdata;
    logic [7:0]  rd;
    int          err_count, compares, cycles;

    spdif_rx_err_out u_spdif_rx_err_out (
        .i_mclk, .i_rst_n, .i_frame_stb, .i_parity_err, .i_sample_l,
        .i_sample_r, .i_cs_byte0, .i_block_stb, .i_pre_b_seen(i_pre),
        .i_pre_a_seen(i_pre), .i_pre_bb_seen(i_pre), .i_pll_err,
        .i_fs_changed, .i_fs_meas, .i_rx_master_clock, .i_rx_bit_clock,
        .i_rx_word_clock, .i_rx_data, .i_xtal_mclk, .i_xtal_bclk,
        .i_xtal_lrclk, .i_aux_serial_in, .i_gpio, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .o_data_l, .o_data_r, .o_cs_byte0,
        .o_fs_meas, .o_data_valid, .o_error_flag_out, .o_nonpcm,
        .o_multi_status_out, .o_irq_n, .o_locked, .o_mclk, .o_bclk,
        .o_lrclk, .o_sdata
    );

    spdif_src_model u_spdif_src_model (
        .i_mclk, .o_frame_stb(i_frame_stb), .o_parity_err(i_parity_err),
        .o_sample_l(i_sample_l), .o_sample_r(i_sample_r),
        .o_word_clock(i_rx_word_clock), .o_block_stb(i_block_stb)
    );

    initial begin
        i_mclk = 1'h0;
        forever #4 i_mclk = ~i_mclk;
    end

    task automatic print_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk(input string n, input logic [23:0] e,
                       input logic [23:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'h1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'h0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd   <= 1'h1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'h0;
        #1;
        d = o_rdata;
    endtask

    task automatic frame(input logic [23:0] l, input logic perr);
        u_spdif_src_model.send(l, ~l, perr, 1'h0);
        repeat (2) @(posedge i_mclk);
        #1;
    endtask

    // Frame that also closes a channel status block
    task automatic blk_frame(input logic [23:0] l, input logic perr);
        u_spdif_src_model.send(l, ~l, perr, 1'h1);
        repeat (2) @(posedge i_mclk);
        #1;
    endtask

    task automatic wait_err(input logic v);
        int n;
        n = 0;
        while (o_error_flag_out !== v && n < 8000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk("error flag", {23'h0, v}, {23'h0, o_error_flag_out});
    endtask

    task automatic t_reset();
        chk("flag in reset", 24'h1, {23'h0, o_error_flag_out});
        chk("irq in reset", 24'h1, {23'h0, o_irq_n});
        chk("data in reset", 24'h0, o_data_l);
    endtask

    task automatic t_lock();
        i_pre <= 1'h1;
        wait_err(1'h0);
        repeat (8) @(posedge i_mclk);
        chk("locked", 24'h1, {23'h0, o_locked});
        reg_rd(`ADDR_STAT, rd);
        chk("status lock", 24'h1, {23'h0, rd[2]});
        reg_rd(4'hA, rd);
        chk("unmapped read", 24'h0, {16'h0, rd});
    endtask

    task automatic t_pcm();
        i_cs_byte0 <= 8'h00;
        frame(24'h123456, 1'h0);
        chk("valid", 24'h1, {23'h0, o_data_valid});
        frame(24'hABCDEF, 1'h1);
        chk("pcm conceal l", 24'h123456, o_data_l);
        chk("pcm conceal r", ~24'h123456, o_data_r);
        repeat (7) frame(24'hABCDEF, 1'h1);
        chk("eight errors", 24'h123456, o_data_l);
        frame(24'h00C0DE, 1'h0);
        repeat (8) frame(24'h555555, 1'h1);
        chk("count cleared", 24'h00C0DE, o_data_l);
    endtask

    task automatic t_nonpcm();
        i_cs_byte0 <= 8'h02;
        frame(24'h111111, 1'h0);
        blk_frame(24'h111111, 1'h0);
        chk("nonpcm pin", 24'h1, {23'h0, o_nonpcm});
        i_cs_byte0 <= 8'h00;
        blk_frame(24'h222222, 1'h1);
        chk("nonpcm pass", 24'h222222, o_data_l);
        chk("cs held", 24'h2, {16'h0, o_cs_byte0});
        frame(24'h333333, 1'h0);
    endtask

    task automatic t_emph();
        reg_wr(`ADDR_CTRL, 8'h02);
        i_cs_byte0 <= 8'h08;
        frame(24'h444444, 1'h0);
        chk("emphasis on", 24'h1, {23'h0, o_multi_status_out});
        i_cs_byte0 <= 8'h00;
        frame(24'h444444, 1'h0);
        chk("emphasis off", 24'h0, {23'h0, o_multi_status_out});
    endtask

    task automatic t_sync();
        reg_wr(`ADDR_CTRL, 8'h05);
        frame({`IEC_SYNC_PA, 8'h00}, 1'h0);
        chk("sync irq", 24'h0, {23'h0, o_irq_n});
        chk("sync on pin", 24'h1, {23'h0, o_nonpcm});
        reg_rd(`ADDR_STAT, rd);
        chk("sync flag", 24'h1, {23'h0, rd[0]});
        @(posedge i_mclk);
        i_fs_changed <= 1'h1;
        @(posedge i_mclk);
        i_fs_changed <= 1'h0;
        repeat (2) @(posedge i_mclk);
        #1;
        chk("sync cleared", 24'h1, {23'h0, o_irq_n});
        blk_frame(24'h000000, 1'h0);
        frame({`IEC_SYNC_PB, 8'h00}, 1'h0);
        chk("pcm no sync", 24'h1, {23'h0, o_irq_n});
    endtask

    task automatic t_sel();
        i_rx_master_clock <= 1'h1;
        i_rx_bit_clock    <= 1'h0;
        i_rx_data         <= 1'h1;
        i_gpio            <= 4'h9;
        reg_wr(`ADDR_CTRL, 8'h38);
        repeat (5) @(posedge i_mclk);
        chk("ext mclk inv", 24'h0, {23'h0, o_mclk});
        chk("ext bclk", 24'h0, {23'h0, o_bclk});
        chk("ext lrclk", 24'h0, {23'h0, o_lrclk});
        chk("ext data", 24'h1, {23'h0, o_sdata});
        reg_wr(`ADDR_CTRL, 8'h78);
        repeat (5) @(posedge i_mclk);
        chk("ext mute", 24'h0, {23'h0, o_sdata});
        i_rx_bit_clock <= 1'h1;
        reg_wr(`ADDR_CTRL, 8'h70);
        repeat (5) @(posedge i_mclk);
        chk("rx mclk", 24'h1, {23'h0, o_mclk});
        chk("rx bclk", 24'h1, {23'h0, o_bclk});
        chk("rx data", 24'h1, {23'h0, o_sdata});
        reg_wr(`ADDR_CTRL, 8'h00);
    endtask

    task automatic t_mute();
        i_cs_byte0 <= 8'h02;
        blk_frame(24'h666666, 1'h0);
        repeat (9) frame(24'h777777, 1'h1);
        chk("mute data", 24'h0, o_data_l);
        chk("mute valid", 24'h0, {23'h0, o_data_valid});
        chk("mute status", 24'h0, {16'h0, o_cs_byte0});
        chk("fs kept", 24'h5, {20'h0, o_fs_meas});
        wait_err(1'h1);
        i_cs_byte0 <= 8'h00;
        repeat (2) @(posedge i_mclk);
        #1;
        chk("nonpcm in error", 24'h0, {23'h0, o_nonpcm});
        frame(24'h888888, 1'h0);
        wait_err(1'h0);
        frame(24'h999999, 1'h0);
        chk("held muted", 24'h0, o_data_l);
        repeat (8) @(posedge i_mclk);
        frame(24'h999999, 1'h0);
        chk("restart", 24'h999999, o_data_l);
    endtask

    task automatic t_lockerr();
        i_pll_err <= 1'h1;
        frame(24'hAAAAAA, 1'h0);
        repeat (4) @(posedge i_mclk);
        chk("lock lost", 24'h0, {23'h0, o_locked});
        chk("fs forced", 24'h0, {20'h0, o_fs_meas});
        chk("lock mute", 24'h0, o_data_l);
        chk("xtal mclk", 24'h0, {23'h0, o_mclk});
        chk("aux data", 24'h0, {23'h0, o_sdata});
        wait_err(1'h1);
        chk("irq idle", 24'h1, {23'h0, o_irq_n});
        i_pll_err <= 1'h0;
    endtask

    initial begin
        {i_rst_n, i_pre, i_pll_err, i_fs_changed} = 4'h0;
        {i_rx_master_clock, i_rx_bit_clock, i_rx_data, i_wr, i_rd} = 5'h0;
        {i_xtal_mclk, i_xtal_bclk, i_xtal_lrclk, i_aux_serial_in} = 4'h0;
        i_cs_byte0 = 8'h00;
        i_wdata    = 8'h00;
        i_fs_meas  = 4'h5;
        i_gpio     = 4'h0;
        i_addr     = 4'h0;
        err_count  = 0;
        compares   = 0;
        cycles     = 0;
        repeat (20) @(posedge i_mclk);
        #1;
        t_reset();
        @(posedge i_mclk);
        i_rst_n <= 1'h1;
        t_lock();
        t_pcm();
        t_nonpcm();
        t_emph();
        t_sync();
        t_sel();
        t_mute();
        t_lockerr();
        print_verdict();
    end
endmodule
